// ### adcsq_pkg.sv
// constants and types of the converter sequencer
package adcsq_pkg;
   localparam logic [7:0] ADR_EX_SW = 8'hf7;
   localparam logic [7:0] ADR_SETUP = 8'hf6;
   localparam logic [7:0] ADR_FIFO_H = 8'hf5;
   localparam logic [7:0] ADR_FIFO_L = 8'hf4;
   localparam logic [7:0] ADR_CHANN = 8'hf3;
   localparam logic [7:0] ADR_CTRL = 8'hf2;
   localparam logic [7:0] ADR_STAT = 8'hf1;
   localparam logic [7:0] ADR_CK_SE = 8'hef;
   localparam logic [7:0] ADR_DMA_CN = 8'hee;
   localparam logic [7:0] ADR_DMA_AH = 8'hed;
   localparam logic [7:0] ADR_DMA_AL = 8'hec;
   // setup register bits
   localparam int SU_DMA = 7;
   localparam int SU_IE_OV = 6;
   localparam int SU_IE_A7 = 5;
   localparam int SU_IE_ACT = 4;
   localparam int SU_CLK = 3;
   // status register bits
   localparam int ST_DMA_END = 7;
   localparam int ST_OV = 6;
   localparam int ST_A7 = 5;
   localparam int ST_ACT = 4;
   // control register bits
   localparam int CT_SAMPLE = 7;
   localparam int CT_WIDTH = 6;
   localparam logic [7:0] RST_EX_SW = 8'h00;
   localparam logic [7:0] RST_SETUP = 8'h00;
   localparam logic [7:0] RST_CHANN = 8'h00;
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [6:0] RST_CK_SE = 7'h10;
   localparam logic [7:0] RST_DMA_CN = 8'h00;
   localparam logic [1:0] FIFO_FULL = 2'h2;
   localparam logic [11:0] DMA_STEP = 12'h002;
   typedef enum logic [1:0] {
      CH_MANUAL, CH_AUTO_0_1, CH_AUTO_6_4, CH_AUTO_6_7
   } adcsq_mode_t;
   typedef struct packed {
      logic [11:0] addr;
      logic [15:0] data;
   } adcsq_dma_t;
   typedef struct packed {
      logic tie_in7_high;
      logic tie_in6_low;
      logic tie_in5_high;
      logic tie_in4_low;
      logic switch_resistance_sel;
      logic resolution_sel;
      logic [1:0] level_check_delay;
   } adcsq_switch_t;
   typedef struct packed {
      logic converter_power_on;
      logic switch_power_on;
      logic level_check_power_on;
   } adcsq_power_t;
endpackage

// ### adcsq_top.sv
// converter sequencer: sampling, result fifo, dma and sfr registers
// Summary of operation
// - channel mode: manual register, or auto pairs AIN0/1, AIN6/4, AIN6/7
// - upper four bits of fifo high byte always read zero
// - setup bit 7 enables dma and the dma completion interrupt
// - setup bits 6,5,4 enable overflow, AIN7 low and done interrupts
// - setup bit 3 reads the converter clock level
// - setup bits 2,1,0 power converter, switches and level check
// - switch bits 7..4 tie AIN7 high, AIN6 low, AIN5 high, AIN4 low
// - switch bit 3 picks low (1) or high (0) switch resistance
// - switch bit 2 picks eleven-bit (1) or ten-bit (0) results
// - two-bit AIN7 check delay: none, maximum, long, short
// - each fifo word read removes the oldest entry
// - manual mode converts exactly once per sample pulse
// - each finished conversion sets done flag and enters the fifo unless the fifo is full
// - fifo word: bits 0..10 value, bit 11 auto channel indicator
// - zero sample cycle is manual, nonzero is automatic period
// - fill count 0,1,2; empty read gives the latest result
// - done and overflow flags clear when written with one
// - dma steps address, counts words down, flags completion
`timescale 1ns/100ps
module adcsq_top
   import adcsq_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   output logic [7:0] channel_select,
   output logic conv_start,
   input wire logic conv_done,
   input wire logic [10:0] conv_value,
   input wire logic in7_low_level,
   output adcsq_pkg::adcsq_switch_t switch_ctl,
   output adcsq_pkg::adcsq_power_t power_ctl,
   output logic dma_req,
   output adcsq_pkg::adcsq_dma_t dma_bus,
   input wire logic dma_ack,
   output logic irq
);
   import adcsq_pkg::*;

   logic [7:0] setup_r, ex_sw_r, chann_r, ctrl_r, dma_cn_r, stat_r;
   logic [6:0] ck_se_r, div_cnt_r;
   logic chk_clk_sel_r;
   logic [11:0] dma_addr_r;
   logic conv_clk_r, conv_rise, tick;
   logic [3:0] cyc_cnt_r;
   logic [1:0] samp_left_r;
   logic samp_prev_r, start_nxt, chan_id_r;
   logic [11:0] fifo_q [0:1];
   logic [11:0] last_r, new_word;
   logic [1:0] cnt_r;
   logic [3:0] hold_hi_r;
   logic in7_prev_r;
   logic push, pop, sw_pop, dma_pop, auto_samp;
   adcsq_mode_t mode;

   function automatic logic [7:0] chan_onehot(input adcsq_mode_t m,
      input logic id, input logic [7:0] sel);
      case (m)
         CH_AUTO_0_1: chan_onehot = id ? 8'h02 : 8'h01;
         CH_AUTO_6_4: chan_onehot = id ? 8'h10 : 8'h40;
         CH_AUTO_6_7: chan_onehot = id ? 8'h80 : 8'h40;
         default: chan_onehot = sel;
      endcase
   endfunction

   function automatic logic wr_at(input logic [7:0] a);
      wr_at = sfr_wr && (sfr_addr == a);
   endfunction

   assign mode = adcsq_mode_t'(ctrl_r[5:4]);
   assign auto_samp = ctrl_r[3:0] != 4'h0;
   // software keeps channel select one-hot; in manual mode it is passed through as is
   assign channel_select = chan_onehot(mode, chan_id_r, chann_r);

   assign power_ctl.converter_power_on = setup_r[2];
   assign power_ctl.switch_power_on = setup_r[1];
   assign power_ctl.level_check_power_on = setup_r[0];
   assign switch_ctl = adcsq_switch_t'(ex_sw_r);

   // register writes
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         setup_r <= RST_SETUP;
         ex_sw_r <= RST_EX_SW;
         chann_r <= RST_CHANN;
         ck_se_r <= RST_CK_SE;
         chk_clk_sel_r <= 1'b0;
      end else begin
         if (wr_at(ADR_SETUP)) begin
            setup_r <= sfr_wdata;
         end
         if (wr_at(ADR_EX_SW)) begin
            ex_sw_r <= sfr_wdata;
         end
         if (wr_at(ADR_CHANN)) begin
            chann_r <= sfr_wdata;
         end
         if (wr_at(ADR_CK_SE)) begin
            ck_se_r <= sfr_wdata[6:0];
            chk_clk_sel_r <= sfr_wdata[7];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_r <= RST_CTRL;
      end else if (wr_at(ADR_CTRL)) begin
         ctrl_r <= sfr_wdata;
      end
   end

   // converter clock: half period of ck_se system clocks, zero acts as one
   assign tick = ({1'b0, div_cnt_r} + 8'h01) >=
      ((ck_se_r == 7'h00) ? 8'h01 : {1'b0, ck_se_r});
   assign conv_rise = tick && !conv_clk_r;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         div_cnt_r <= 7'h00;
         conv_clk_r <= 1'b0;
      end else if (tick) begin
         div_cnt_r <= 7'h00;
         conv_clk_r <= !conv_clk_r;
      end else begin
         div_cnt_r <= div_cnt_r + 7'h01;
      end
   end

   // sampling pulses; in manual mode only a rising sample bit starts
   always_comb begin
      if (auto_samp) begin
         start_nxt = conv_rise && (cyc_cnt_r + 4'h1 >= ctrl_r[3:0]);
      end else begin
         start_nxt = ctrl_r[CT_SAMPLE] && !samp_prev_r;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cyc_cnt_r <= 4'h0;
         samp_left_r <= 2'h0;
         samp_prev_r <= 1'b0;
         conv_start <= 1'b0;
      end else begin
         samp_prev_r <= ctrl_r[CT_SAMPLE];
         conv_start <= start_nxt;
         if (!auto_samp || start_nxt) begin
            cyc_cnt_r <= 4'h0;
         end else if (conv_rise) begin
            cyc_cnt_r <= cyc_cnt_r + 4'h1;
         end
         if (start_nxt && auto_samp) begin
            samp_left_r <= ctrl_r[CT_WIDTH] ? 2'h2 : 2'h1;
         end else if (conv_rise && samp_left_r != 2'h0) begin
            samp_left_r <= samp_left_r - 2'h1;
         end
      end
   end

   // automatic channel indicator flips after each result
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         chan_id_r <= 1'b0;
      end else if (mode == CH_MANUAL) begin
         chan_id_r <= 1'b0;
      end else if (conv_done) begin
         chan_id_r <= !chan_id_r;
      end
   end

   // result fifo, two words deep
   assign new_word = {(mode != CH_MANUAL) && chan_id_r, conv_value};
   assign push = conv_done;
   assign sw_pop = sfr_rd && sfr_addr == ADR_FIFO_L && cnt_r != 2'h0;
   assign dma_req = setup_r[SU_DMA] && dma_cn_r != 8'h00
      && cnt_r != 2'h0;
   assign dma_pop = dma_req && dma_ack && !sw_pop;
   assign pop = sw_pop || dma_pop;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_r <= 2'h0;
         last_r <= 12'h000;
         fifo_q[0] <= 12'h000;
         fifo_q[1] <= 12'h000;
      end else begin
         if (push) begin
            last_r <= new_word;
         end
         if (pop && push) begin
            if (cnt_r == 2'h1) begin
               fifo_q[0] <= new_word;
            end else begin
               fifo_q[0] <= fifo_q[1];
               fifo_q[1] <= new_word;
            end
         end else if (pop) begin
            fifo_q[0] <= fifo_q[1];
            cnt_r <= cnt_r - 2'h1;
         end else if (push && cnt_r != FIFO_FULL) begin
            fifo_q[cnt_r[0]] <= new_word;
            cnt_r <= cnt_r + 2'h1;
         end
      end
   end

   // dma: word address steps by two, count runs down
   assign dma_bus.addr = dma_addr_r;
   assign dma_bus.data = {4'h0, fifo_q[0]};

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dma_addr_r <= 12'h000;
         dma_cn_r <= RST_DMA_CN;
      end else begin
         if (wr_at(ADR_DMA_AH)) begin
            dma_addr_r[11:8] <= sfr_wdata[3:0];
         end else if (wr_at(ADR_DMA_AL)) begin
            dma_addr_r[7:0] <= {sfr_wdata[7:1], 1'b0};
         end else if (dma_pop) begin
            dma_addr_r <= dma_addr_r + DMA_STEP;
         end
         if (wr_at(ADR_DMA_CN)) begin
            dma_cn_r <= sfr_wdata;
         end else if (dma_pop) begin
            dma_cn_r <= dma_cn_r - 8'h01;
         end
      end
   end

   // status flags: hardware set beats a write-one clear
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stat_r <= 8'h00;
         in7_prev_r <= 1'b0;
      end else begin
         in7_prev_r <= in7_low_level;
         if (dma_pop && dma_cn_r == 8'h01) begin
            stat_r[ST_DMA_END] <= 1'b1;
         end else if (wr_at(ADR_DMA_CN) ||
               (wr_at(ADR_STAT) && sfr_wdata[ST_DMA_END])) begin
            stat_r[ST_DMA_END] <= 1'b0;
         end
         if (push && !pop && cnt_r == FIFO_FULL) begin
            stat_r[ST_OV] <= 1'b1;
         end else if (wr_at(ADR_STAT) && sfr_wdata[ST_OV]) begin
            stat_r[ST_OV] <= 1'b0;
         end
         if (setup_r[0] && in7_low_level && !in7_prev_r) begin
            stat_r[ST_A7] <= 1'b1;
         end else if (wr_at(ADR_STAT) && sfr_wdata[ST_A7]) begin
            stat_r[ST_A7] <= 1'b0;
         end
         if (push) begin
            stat_r[ST_ACT] <= 1'b1;
         end else if (wr_at(ADR_STAT) && sfr_wdata[ST_ACT]) begin
            stat_r[ST_ACT] <= 1'b0;
         end
      end
   end

   assign irq = (stat_r[ST_DMA_END] && setup_r[SU_DMA])
      || (stat_r[ST_OV] && setup_r[SU_IE_OV])
      || (stat_r[ST_A7] && setup_r[SU_IE_A7])
      || (stat_r[ST_ACT] && setup_r[SU_IE_ACT]);

   // read port, answered one cycle after the strobe
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sfr_rdata <= 8'h00;
         hold_hi_r <= 4'h0;
      end else if (sfr_rd) begin
         if (sfr_addr == ADR_FIFO_L) begin
            // empty fifo returns the latest result
            sfr_rdata <= (cnt_r == 2'h0) ? last_r[7:0] : fifo_q[0][7:0];
            hold_hi_r <= (cnt_r == 2'h0) ? last_r[11:8] : fifo_q[0][11:8];
         end else if (sfr_addr == ADR_FIFO_H) begin
            sfr_rdata <= {4'h0, hold_hi_r};
         end else if (sfr_addr == ADR_SETUP) begin
            sfr_rdata <= {setup_r[7:4], conv_clk_r, setup_r[2:0]};
         end else if (sfr_addr == ADR_EX_SW) begin
            sfr_rdata <= ex_sw_r;
         end else if (sfr_addr == ADR_CHANN) begin
            sfr_rdata <= chann_r;
         end else if (sfr_addr == ADR_CTRL) begin
            sfr_rdata <= {auto_samp ? samp_left_r != 2'h0 :
               ctrl_r[CT_SAMPLE], ctrl_r[6:0]};
         end else if (sfr_addr == ADR_STAT) begin
            sfr_rdata <= {stat_r[7:4], in7_low_level,
               (mode != CH_MANUAL) ? chan_id_r : cnt_r != 2'h0,
               cnt_r};
         end else if (sfr_addr == ADR_CK_SE) begin
            sfr_rdata <= {chk_clk_sel_r, ck_se_r};
         end else if (sfr_addr == ADR_DMA_CN) begin
            sfr_rdata <= dma_cn_r;
         end else if (sfr_addr == ADR_DMA_AH) begin
            sfr_rdata <= {4'h0, dma_addr_r[11:8]};
         end else if (sfr_addr == ADR_DMA_AL) begin
            sfr_rdata <= dma_addr_r[7:0];
         end else begin
            sfr_rdata <= 8'h00;
         end
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   manual_start_a: assert property (
      (!auto_samp && ctrl_r[CT_SAMPLE] && !samp_prev_r) |=> conv_start)
      else $error("manual pulse gave no start");
   manual_idle_a: assert property (
      (!auto_samp && !(ctrl_r[CT_SAMPLE] && !samp_prev_r)) |=> !conv_start)
      else $error("start without a manual pulse");
   done_flag_a: assert property (
      conv_done |=> stat_r[ST_ACT] && cnt_r != 2'h0)
      else $error("result not flagged or stored");
   fifo_high_a: assert property (
      (sfr_rd && sfr_addr == ADR_FIFO_H) |=> sfr_rdata[7:4] == 4'h0)
      else $error("fifo high nibble not zero");
   overflow_a: assert property (
      (push && !pop && cnt_r == FIFO_FULL) |=> stat_r[ST_OV] && cnt_r == 2'h2)
      else $error("overflow not flagged");
   read_pop_a: assert property (
      (sw_pop && !push) |=> cnt_r == $past(cnt_r) - 2'h1)
      else $error("fifo read did not remove entry");
   irq_done_a: assert property (
      ($rose(stat_r[ST_ACT]) && setup_r[SU_IE_ACT]) |-> irq)
      else $error("enabled done flag gave no interrupt");
   dma_step_a: assert property (
      (dma_pop && !sfr_wr) |=> dma_addr_r == $past(dma_addr_r) + DMA_STEP
         && dma_cn_r == $past(dma_cn_r) - 8'h01)
      else $error("dma address or count did not step");
endmodule

// ### adcsq_core_model.sv
// behavioural converter core answering start pulses
`timescale 1ns/100ps
module adcsq_core_model (
   input wire logic clk,
   input wire logic conv_start,
   input wire logic slow,
   output logic conv_done,
   output logic [10:0] conv_value
);
   int wait_c = -1;
   logic [10:0] seq = 11'h4c0;
   initial conv_done = 1'b0;
   initial conv_value = 11'h7ff;
   always @(posedge clk) begin
      conv_done <= 1'b0;
      // lines scramble outside the done pulse, no stale value to lean on
      conv_value <= ~conv_value;
      if (conv_start && wait_c < 0) begin
         wait_c <= slow ? 20 : 2;
      end else if (wait_c == 0) begin
         conv_done <= 1'b1;
         conv_value <= seq;
         seq <= seq + 11'h001;
         wait_c <= -1;
      end else if (wait_c > 0) begin
         wait_c <= wait_c - 1;
      end
   end
endmodule

// ### adc_sequencer_fifo_dma_bench.sv
// self-checking bench of the converter sequencer
`timescale 1ns/100ps
module adc_sequencer_fifo_dma_bench;
   import adcsq_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] sfr_addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata;
   logic [7:0] channel_select;
   logic conv_start;
   logic conv_done;
   logic [10:0] conv_value;
   logic in7_low_level = 1'b0;
   adcsq_switch_t switch_ctl;
   adcsq_power_t power_ctl;
   logic dma_req;
   adcsq_dma_t dma_bus;
   logic dma_ack = 1'b0;
   logic irq;
   logic slow = 1'b0;
   int fails = 0;
   int comparisons = 0;
   int n_start = 0;
   int n_done = 0;
   logic [7:0] sel_log [0:255];
   logic [7:0] d;
   always #2.5 clk = ~clk;
   adcsq_top i_dut (
      .clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .channel_select(channel_select), .conv_start(conv_start),
      .conv_done(conv_done), .conv_value(conv_value),
      .in7_low_level(in7_low_level), .switch_ctl(switch_ctl),
      .power_ctl(power_ctl), .dma_req(dma_req), .dma_bus(dma_bus),
      .dma_ack(dma_ack), .irq(irq));
   adcsq_core_model i_core (
      .clk(clk), .conv_start(conv_start), .slow(slow),
      .conv_done(conv_done), .conv_value(conv_value));
   always @(posedge clk) begin
      if (conv_start) begin
         sel_log[n_start[7:0]] <= channel_select;
         n_start <= n_start + 1;
      end
      if (conv_done)
         n_done <= n_done + 1;
   end
   task automatic complete_run();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp,
         input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic hang(input logic ok);
      if (ok !== 1'b1) begin
         fails++;
         $display("[FAIL] wait expected event seen timeout");
         complete_run();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge clk);
      sfr_addr = a;
      sfr_wdata = v;
      sfr_wr = 1'b1;
      @(negedge clk);
      sfr_wr = 1'b0;
   endtask
   // one spare cycle so either read latency reading is covered
   task automatic rd(input logic [7:0] a);
      @(negedge clk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clk);
      sfr_rd = 1'b0;
      @(negedge clk);
      d = sfr_rdata;
   endtask
   function automatic logic [10:0] ev(input int k);
      ev = 11'h4c0 + k[10:0];
   endfunction
   task automatic pulse();
      int i;
      int t;
      t = n_done + 1;
      wr(ADR_CTRL, 8'h80);
      repeat (34) @(negedge clk);
      wr(ADR_CTRL, 8'h00);
      for (i = 0; i < 400 && n_done < t; i++)
         @(negedge clk);
      hang(n_done >= t);
      repeat (2) @(negedge clk);
   endtask
   // id is the expected auto channel indicator in bit 11
   task automatic read_word(input int k, input logic id);
      logic [7:0] lo;
      rd(ADR_FIFO_L);
      lo = d;
      rd(ADR_FIFO_H);
      chk("fifo word", {20'h0, id, ev(k)}, {16'h0, d, lo});
   endtask
   task automatic t_reset();
      chk("idle outs", 32'h0, {18'h0, dma_req, irq, conv_start,
         power_ctl, switch_ctl});
      rd(ADR_CHANN);
      chk("channel reg", 32'h00, {24'h0, d});
      // reset divisor gives a 6.25 MHz converter clock, inside the limit
      rd(ADR_CK_SE);
      chk("divisor reg", 32'h10, {24'h0, d});
      rd(ADR_DMA_CN);
      chk("dma count", 32'h00, {24'h0, d});
      rd(8'hf0);
      chk("unmapped", 32'h00, {24'h0, d});
      rd(ADR_STAT);
      chk("status", 32'h00, {24'h0, d & 8'hf3});
      $display("test reset done");
   endtask
   task automatic t_config();
      logic [7:0] c;
      wr(ADR_EX_SW, 8'ha5);
      wr(ADR_SETUP, 8'h07);
      chk("switch", 32'ha5, {24'h0, switch_ctl});
      wr(ADR_EX_SW, 8'h5a);
      chk("power", 32'h7, {29'h0, power_ctl});
      rd(ADR_EX_SW);
      chk("switch reg", 32'h5a, {24'h0, d});
      chk("switch", 32'h5a, {24'h0, switch_ctl});
      rd(ADR_SETUP);
      chk("setup reg", 32'h07, {24'h0, d & 8'hf7});
      // two samples sixteen clocks apart straddle one clock toggle
      c = d;
      repeat (13) @(negedge clk);
      rd(ADR_SETUP);
      chk("clock level", 32'h08, {24'h0, (c ^ d) & 8'h08});
      $display("test config done");
   endtask
   task automatic t_manual();
      int s;
      wr(ADR_CHANN, 8'h01);
      chk("channel", 32'h01, {24'h0, channel_select});
      s = n_start;
      pulse();
      rd(ADR_STAT);
      chk("status", 32'h15, {24'h0, d});
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(ADR_SETUP, 8'h17);
      chk("irq", 32'h1, {31'h0, irq});
      wr(ADR_STAT, 8'h10);
      chk("irq", 32'h0, {31'h0, irq});
      read_word(0, 1'b0);
      repeat (60) @(negedge clk);
      chk("starts", 32'h1, n_start - s);
      rd(ADR_STAT);
      chk("status", 32'h00, {24'h0, d});
      $display("test manual done");
   endtask
   task automatic t_overflow();
      slow = 1'b1;
      wr(ADR_SETUP, 8'h47);
      repeat (3) pulse();
      rd(ADR_STAT);
      chk("status", 32'h56, {24'h0, d});
      chk("irq", 32'h1, {31'h0, irq});
      read_word(1, 1'b0);
      read_word(2, 1'b0);
      rd(ADR_FIFO_L);
      chk("empty read", {21'h0, ev(3) & 11'h0ff}, {24'h0, d});
      wr(ADR_STAT, 8'h50);
      rd(ADR_STAT);
      chk("status", 32'h00, {24'h0, d});
      slow = 1'b0;
      $display("test overflow done");
   endtask
   task automatic t_level();
      wr(ADR_SETUP, 8'h27);
      in7_low_level = 1'b1;
      repeat (3) @(negedge clk);
      chk("irq", 32'h1, {31'h0, irq});
      rd(ADR_STAT);
      chk("low flag", 32'h20, {24'h0, d & 8'h20});
      in7_low_level = 1'b0;
      wr(ADR_STAT, 8'h20);
      chk("irq", 32'h0, {31'h0, irq});
      $display("test level done");
   endtask
   task automatic t_dma();
      int i;
      int k;
      logic [11:0] a;
      a = 12'h110;
      repeat (2) pulse();
      wr(ADR_DMA_AL, 8'h10);
      wr(ADR_DMA_AH, 8'h01);
      wr(ADR_DMA_CN, 8'h02);
      wr(ADR_SETUP, 8'h87);
      for (k = 0; k < 2; k++) begin
         for (i = 0; i < 20 && dma_req !== 1'b1; i++)
            @(negedge clk);
         hang(dma_req);
         chk("dma word", {4'h0, a, 5'h0, ev(4 + k)}, {4'h0, dma_bus});
         dma_ack = 1'b1;
         @(negedge clk);
         dma_ack = 1'b0;
         a = a + 12'h002;
      end
      repeat (2) @(negedge clk);
      chk("dma end", 32'h1, {30'h0, dma_req, irq});
      rd(ADR_STAT);
      chk("status", 32'h90, {24'h0, d});
      rd(ADR_DMA_CN);
      chk("dma count", 32'h00, {24'h0, d});
      rd(ADR_DMA_AL);
      chk("dma addr", 32'h14, {24'h0, d});
      wr(ADR_STAT, 8'h90);
      wr(ADR_SETUP, 8'h07);
      $display("test dma done");
   endtask
   task automatic t_auto();
      int i;
      int m;
      int s;
      logic [7:0] pm [1:3];
      pm = '{8'h03, 8'h50, 8'hc0};
      for (m = 1; m < 4; m++) begin
         wr(ADR_CTRL, {2'b00, m[1:0], 4'h1});
         s = n_start + 3;
         for (i = 0; i < 600 && n_start < s; i++)
            @(negedge clk);
         hang(n_start >= s);
         chk("pair", {16'h0, pm[m], pm[m]}, {16'h0,
            sel_log[s - 1] | sel_log[s - 2],
            sel_log[s - 1] ^ sel_log[s - 2]});
         wr(ADR_CTRL, 8'h00);
         // let a conversion in flight land before draining
         repeat (40) @(negedge clk);
         // first stored result came from indicator 0, the second from 1
         read_word(3 * m + 3, 1'b0);
         read_word(3 * m + 4, 1'b1);
         wr(ADR_STAT, 8'hf0);
      end
      $display("test auto done");
   endtask
   initial begin
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      t_reset();
      t_config();
      t_manual();
      t_overflow();
      t_level();
      t_dma();
      t_auto();
      complete_run();
   end
endmodule
